// ===== dv/master_model.sv
// Network master model: register requests and port pin levels for the slave state block
`timescale 1ns/10ps
`default_nettype none
`include "slave_state_defs.svh"

module master_model (
    // Clock
    input wire logic clk,
    // Avalon-MM master side
    output logic [3:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Port link levels
    output slave_state_pkg::port_status_t port_pins
);
    import slave_state_pkg::*;

    // Idle bus at time zero
    initial begin
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        port_pins = '0;
    end

    // ==========================================
    // Bus cycle: the request is held until waitrequest is seen low at an edge
    task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_writedata <= ~d;  // Released lines must not keep the last value
    endtask

    // ==========================================
    // State request; bit 10 makes the application refuse the change
    task automatic request(input logic [3:0] st, input logic fail);
        logic [31:0] q;
        xfer(1'b1, `REG_CONTROL, {21'h0, fail, 1'b0, 1'b1, 4'h0, st}, q);
    endtask

    // Error clear request, no state request in the same word
    task automatic clear_error();
        logic [31:0] q;
        xfer(1'b1, `REG_CONTROL, 32'h200, q);
    endtask

    // Link levels change on a clock edge, like a real pin synchroniser sees them
    task automatic set_ports(input port_status_t p);
        @(posedge clk);
        port_pins <= p;
    endtask
endmodule  // master_model
`default_nettype wire

// ===== dv/slave_state_test.sv
// Self-checking testbench of the slave state block
`timescale 1ns/10ps
`default_nettype none
`include "slave_state_defs.svh"

module slave_state_test;
    import slave_state_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    port_status_t port_pins;
    logic irq;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;

    // ==========================================
    // Clock, design and master
    always #25 clk = ~clk;

    slave_state u_dut (.clk(clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .port_pins(port_pins), .irq(irq));

    master_model u_master (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .port_pins(port_pins));

    // ==========================================
    // Comparison and bus helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        u_master.xfer(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        u_master.xfer(1'b1, a, d, q);
    endtask

    // Request, then one spare cycle so the pending change settles
    task automatic req(input logic [3:0] st, input logic fail);
        u_master.request(st, fail);
        @(posedge clk);
    endtask

    // ==========================================
    // Scenarios
    task automatic test_reset();
        check(avs_readdata, 32'h0);
        check({31'h0, irq}, 32'h0);
        check({31'h0, avs_waitrequest}, 32'h0);
        rd_chk(`REG_STATUS, {28'h0, `ST_INIT});
        rd_chk(`REG_REQUESTED, {28'h0, `ST_INIT});
        rd_chk(`REG_CHANNELS, {`CH_PD_IN, `CH_PD_OUT, `CH_MBX_READ, `CH_MBX_WRITE});
        rd_chk(`REG_IRQ_MASK, 32'h0);
        rd_chk(4'hF, 32'h0);
        $display("test_reset done");
    endtask

    // Every state code, entered and left along legal moves
    task automatic test_walk();
        logic [3:0] seq [8] = '{`ST_BOOT, `ST_INIT, `ST_PRE_OPER, `ST_SAFE_OPER,
                                `ST_OPER, `ST_SAFE_OPER, `ST_PRE_OPER, `ST_INIT};
        foreach (seq[i]) begin
            req(seq[i], 1'b0);
            rd_chk(`REG_STATUS, {28'h0, seq[i]});
            rd_chk(`REG_REQUESTED, {28'h0, seq[i]});
        end
        rd_chk(`REG_IRQ_STATUS, 32'h1);
        rd_chk(`REG_IRQ_STATUS, 32'h0);
        $display("test_walk done");
    endtask

    // Refused and illegal changes keep the state and mark the error
    task automatic test_fail();
        req(`ST_PRE_OPER, 1'b0);
        wr(`REG_IRQ_MASK, 32'h2);
        rd_chk(`REG_IRQ_STATUS, 32'h1);
        req(`ST_SAFE_OPER, 1'b1);
        rd_chk(`REG_STATUS, {27'h0, 1'b1, `ST_PRE_OPER});
        check({31'h0, irq}, 32'h1);
        rd_chk(`REG_IRQ_STATUS, 32'h2);
        @(posedge clk);
        check({31'h0, irq}, 32'h0);
        u_master.clear_error();
        @(posedge clk);
        rd_chk(`REG_STATUS, {28'h0, `ST_PRE_OPER});
        wr(`REG_IRQ_MASK, 32'h0);
        req(`ST_BOOT, 1'b0);
        rd_chk(`REG_STATUS, {27'h0, 1'b1, `ST_PRE_OPER});
        rd_chk(`REG_REQUESTED, {28'h0, `ST_BOOT});
        check({31'h0, irq}, 32'h0);
        rd_chk(`REG_IRQ_STATUS, 32'h2);
        u_master.clear_error();
        @(posedge clk);
        rd_chk(`REG_STATUS, {28'h0, `ST_PRE_OPER});
        // A code outside the five states is ignored: no request, no event
        req(4'h5, 1'b0);
        rd_chk(`REG_REQUESTED, {28'h0, `ST_BOOT});
        rd_chk(`REG_STATUS, {28'h0, `ST_PRE_OPER});
        rd_chk(`REG_IRQ_STATUS, 32'h0);
        $display("test_fail done");
    endtask

    // All four carrier and open combinations, twice over
    task automatic test_ports();
        u_master.set_ports('{carrier: 4'b0011, open: 4'b0101});
        repeat (3) @(posedge clk);
        rd_chk(`REG_PORTS, 32'h35);
        rd_chk(`REG_IRQ_STATUS, 32'h4);
        u_master.set_ports('{carrier: 4'b1100, open: 4'b1010});
        repeat (3) @(posedge clk);
        rd_chk(`REG_PORTS, 32'hCA);
        $display("test_ports done");
    endtask

    // Whole file store written, then read back from the start
    task automatic test_file();
        wr(`REG_FILE_ADDR, 32'h0);
        for (int i = 0; i < `FILE_DEPTH; i++) wr(`REG_FILE_DATA, 32'hA5000000 + i);
        rd_chk(`REG_IRQ_STATUS, 32'hC);
        wr(`REG_FILE_ADDR, 32'h0);
        for (int i = 0; i < `FILE_DEPTH; i++) rd_chk(`REG_FILE_DATA, 32'hA5000000 + i);
        $display("test_file done");
    endtask

    task automatic test_objects();
        logic [31:0] obj [4] = '{32'h1000, 32'h1018, 32'h1C00, 32'h1C13};
        wr(`REG_OBJ_INDEX, 32'h0);
        foreach (obj[i]) rd_chk(`REG_OBJ_DATA, obj[i]);
        $display("test_objects done");
    endtask

    // ==========================================
    // Verdict and hang guard
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            close_out();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        test_reset();
        test_walk();
        test_fail();
        test_ports();
        test_file();
        test_objects();
        close_out();
    end
endmodule  // slave_state_test
`default_nettype wire

// ===== rtl/slave_state.sv
// Application state control, port status, file and object list access for a slave
//
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "slave_state_defs.svh"

module slave_state (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Port link status pins
    input wire slave_state_pkg::port_status_t port_pins,
    // Interrupt
    output logic irq
);
    import slave_state_pkg::*;

    // Valid state code check, used by request decode and assertions
    function automatic logic legal_state(input logic [3:0] s);
        legal_state = (s == `ST_INIT) || (s == `ST_PRE_OPER) || (s == `ST_BOOT) ||
                      (s == `ST_SAFE_OPER) || (s == `ST_OPER);
    endfunction

    // Allowed direct transition; anything else counts as failed
    function automatic logic allowed_move(input logic [3:0] from, input logic [3:0] to);
        allowed_move = (to == `ST_INIT) || (from == to) ||
                       (from == `ST_INIT && (to == `ST_PRE_OPER || to == `ST_BOOT)) ||
                       (from == `ST_PRE_OPER && to == `ST_SAFE_OPER) ||
                       (from == `ST_SAFE_OPER && (to == `ST_OPER || to == `ST_PRE_OPER)) ||
                       (from == `ST_OPER && (to == `ST_SAFE_OPER || to == `ST_PRE_OPER));
    endfunction

    // ==========================================
    // Port pin synchronisers
    port_status_t port_meta_r, port_sync_r, port_prev_r;
    generate
        for (genvar i = 0; i < 1; i++) begin : g_sync
            // Two flops before any logic reads the pins
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    port_meta_r <= '0;
                    port_sync_r <= '0;
                    port_prev_r <= '0;
                end else begin
                    port_meta_r <= port_pins;
                    port_sync_r <= port_meta_r;
                    port_prev_r <= port_sync_r;
                end
            end
        end
    endgenerate

    // ==========================================
    // Bus decode; single-cycle answer, waitrequest low on the first cycle
    logic wr_en, rd_en;
    assign avs_waitrequest = 1'b0;
    assign wr_en = avs_write;
    assign rd_en = avs_read;

    // ==========================================
    // State machine registers
    logic [3:0] cur_r, cur_nxt;
    logic [3:0] req_r, req_nxt;
    logic err_r, err_nxt;
    logic fail_r, fail_nxt;
    chg_state_t chg_r, chg_nxt;
    logic state_ev, err_ev;

    // Requests wait one cycle so a fail flag written with them applies
    always_comb begin
        cur_nxt = cur_r;
        req_nxt = req_r;
        err_nxt = err_r;
        fail_nxt = fail_r;
        chg_nxt = chg_r;
        state_ev = 1'b0;
        err_ev = 1'b0;
        case (chg_r)
            chg_idle: begin
                if (wr_en && avs_address == `REG_CONTROL) begin
                    fail_nxt = avs_writedata[`CTRL_FAIL];
                    if (avs_writedata[`CTRL_CLEAR_ERR])
                        err_nxt = 1'b0; // [R3]
                    if (avs_writedata[`CTRL_REQ_VALID] &&
                        legal_state(avs_writedata[`STATE_W-1:0])) begin
                        req_nxt = avs_writedata[`STATE_W-1:0]; // [R1] [R4]
                        chg_nxt = chg_wait;
                    end
                end
            end
            chg_wait: begin
                chg_nxt = chg_idle;
                if (fail_r || !allowed_move(cur_r, req_r)) begin
                    err_nxt = 1'b1; // [R2] keep prior state
                    err_ev = 1'b1;
                end else if (cur_r != req_r) begin
                    cur_nxt = req_r; // [R1] [R10] only on request
                    state_ev = 1'b1;
                end
            end
            default: chg_nxt = chg_idle;
        endcase
    end

    // Register the state machine
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cur_r <= `ST_INIT;
            req_r <= `ST_INIT;
            err_r <= 1'b0;
            fail_r <= 1'b0;
            chg_r <= chg_idle;
        end else begin
            cur_r <= cur_nxt;
            req_r <= req_nxt;
            err_r <= err_nxt;
            fail_r <= fail_nxt;
            chg_r <= chg_nxt;
        end
    end

    // ==========================================
    // File store and object list
    logic [31:0] file_mem [`FILE_DEPTH];
    logic [`FILE_AW-1:0] faddr_r, faddr_nxt;
    logic [`OBJ_AW-1:0] oidx_r, oidx_nxt;
    logic file_ev;

    // Object list: index of each entry, fixed in hardware
    function automatic logic [31:0] obj_entry(input logic [`OBJ_AW-1:0] i);
        case (i)
            2'h0: obj_entry = 32'h0000_1000;
            2'h1: obj_entry = 32'h0000_1018;
            2'h2: obj_entry = 32'h0000_1C00;
            default: obj_entry = 32'h0000_1C13;
        endcase
    endfunction

    // File pointer auto-increments on each data access
    always_comb begin
        faddr_nxt = faddr_r;
        oidx_nxt = oidx_r;
        file_ev = 1'b0;
        if (wr_en && avs_address == `REG_FILE_ADDR)
            faddr_nxt = avs_writedata[`FILE_AW-1:0];
        else if ((wr_en || rd_en) && avs_address == `REG_FILE_DATA) begin
            faddr_nxt = faddr_r + 1'b1; // [R8]
            file_ev = wr_en && (faddr_r == `FILE_AW'(`FILE_DEPTH - 1));
        end
        if (wr_en && avs_address == `REG_OBJ_INDEX)
            oidx_nxt = avs_writedata[`OBJ_AW-1:0];
        else if (rd_en && avs_address == `REG_OBJ_DATA)
            oidx_nxt = oidx_r + 1'b1; // [R9]
    end

    // Pointers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            faddr_r <= '0;
            oidx_r <= '0;
        end else begin
            faddr_r <= faddr_nxt;
            oidx_r <= oidx_nxt;
        end
    end

    // File memory has no reset; contents are whatever the master last wrote
    always_ff @(posedge clk) begin
        if (wr_en && avs_address == `REG_FILE_DATA)
            file_mem[faddr_r] <= avs_writedata; // [R8]
    end

    // ==========================================
    // Interrupts: sticky status, cleared by reading it; set wins over clear
    logic [`IRQ_W-1:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt, ev;
    always_comb begin
        ev = '0;
        ev[`IRQ_STATE] = state_ev;
        ev[`IRQ_ERROR] = err_ev;
        ev[`IRQ_PORT] = port_sync_r != port_prev_r;
        ev[`IRQ_FILE] = file_ev;
        irq_stat_nxt = irq_stat_r;
        if (rd_en && avs_address == `REG_IRQ_STATUS)
            irq_stat_nxt = '0;
        irq_stat_nxt = irq_stat_nxt | ev;
        irq_mask_nxt = irq_mask_r;
        if (wr_en && avs_address == `REG_IRQ_MASK)
            irq_mask_nxt = avs_writedata[`IRQ_W-1:0];
    end

    // Interrupt registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
        end
    end
    assign irq = |(irq_stat_r & irq_mask_r);

    // ==========================================
    // Read data mux; answer is combinational while avs_read is high, then held by a register
    logic [31:0] rdata_nxt, rdata_r;
    always_comb begin
        rdata_nxt = '0;
        case (avs_address)
            `REG_CONTROL: rdata_nxt = {21'h0, fail_r, 10'h0};
            `REG_STATUS: rdata_nxt = {27'h0, err_r, cur_r}; // [R4] [R10]
            `REG_REQUESTED: rdata_nxt = {28'h0, req_r}; // [R4]
            `REG_PORTS: rdata_nxt = {24'h0, port_sync_r}; // [R5]
            `REG_CHANNELS: rdata_nxt = {`CH_PD_IN, `CH_PD_OUT, `CH_MBX_READ,
                                        `CH_MBX_WRITE}; // [R6] [R7]
            `REG_FILE_ADDR: rdata_nxt = {28'h0, faddr_r};
            `REG_FILE_DATA: rdata_nxt = file_mem[faddr_r]; // [R8]
            `REG_OBJ_INDEX: rdata_nxt = {30'h0, oidx_r};
            `REG_OBJ_DATA: rdata_nxt = obj_entry(oidx_r); // [R9]
            `REG_IRQ_STATUS: rdata_nxt = {28'h0, irq_stat_r};
            `REG_IRQ_MASK: rdata_nxt = {28'h0, irq_mask_r};
            default: rdata_nxt = '0;
        endcase
    end

    // Readdata register; keeps the last answer once the read ends, the mux drives readdata during the read
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            rdata_r <= '0;
        else if (rd_en)
            rdata_r <= rdata_nxt;
    end
    assign avs_readdata = rd_en ? rdata_nxt : rdata_r;

    // ==========================================
    // Checks
    // Request accepted by the decoder while no change is pending
    sequence req_taken;
        chg_r == chg_idle && wr_en && avs_address == `REG_CONTROL &&
        avs_writedata[`CTRL_REQ_VALID] && legal_state(avs_writedata[`STATE_W-1:0]);
    endsequence

    // Request with a code outside the five states; it must leave the pending change, requested and current state as they were
    sequence req_bad_code;
        chg_r == chg_idle && wr_en && avs_address == `REG_CONTROL &&
        avs_writedata[`CTRL_REQ_VALID] && !legal_state(avs_writedata[`STATE_W-1:0]);
    endsequence

    // Pending change that the application refuses or that is not an allowed move
    sequence move_refused;
        chg_r == chg_wait && (fail_r || !allowed_move(cur_r, req_r));
    endsequence

    // State machine
    chk_state_legal: assert property (@(posedge clk) disable iff (reset) // [R1]
        legal_state(cur_r)) else $error("current state code illegal");
    chk_fail_keeps: assert property (@(posedge clk) disable iff (reset) // [R2]
        (chg_r == chg_wait && fail_r) |=> (err_r && $stable(cur_r)))
        else $error("failed change moved state");
    chk_refused_flag: assert property (@(posedge clk) disable iff (reset) // [R2]
        move_refused |=> (err_r && irq_stat_r[`IRQ_ERROR] && $stable(cur_r)))
        else $error("refused change not flagged");
    chk_err_clear: assert property (@(posedge clk) disable iff (reset) // [R3]
        (chg_r == chg_idle && wr_en && avs_address == `REG_CONTROL &&
         avs_writedata[`CTRL_CLEAR_ERR]) |=> !err_r)
        else $error("error flag not cleared");
    chk_req_reach: assert property (@(posedge clk) disable iff (reset) // [R1]
        req_taken ##1 (!fail_r && allowed_move(cur_r, req_r)) |=> cur_r == $past(req_r))
        else $error("request not entered");
    chk_req_record: assert property (@(posedge clk) disable iff (reset) // [R4]
        req_taken |=> (chg_r == chg_wait && req_r == $past(avs_writedata[`STATE_W-1:0])))
        else $error("requested state not recorded");
    chk_bad_code: assert property (@(posedge clk) disable iff (reset) // [R10]
        req_bad_code |=> (chg_r == chg_idle && $stable(req_r) && $stable(cur_r)))
        else $error("illegal request code taken");
    chk_no_drift: assert property (@(posedge clk) disable iff (reset) // [R10]
        chg_r == chg_idle |=> $stable(cur_r))
        else $error("state moved without request");

    // Read paths
    chk_status_word: assert property (@(posedge clk) disable iff (reset) // [R4] [R10]
        (rd_en && avs_address == `REG_STATUS) |->
        avs_readdata == {27'h0, err_r, cur_r})
        else $error("status word wrong");
    chk_port_view: assert property (@(posedge clk) disable iff (reset) // [R5]
        (rd_en && avs_address == `REG_PORTS) |-> avs_readdata[7:0] == port_sync_r)
        else $error("port status wrong");
    chk_chan_roles: assert property (@(posedge clk) disable iff (reset) // [R6] [R7]
        (rd_en && avs_address == `REG_CHANNELS) |->
        avs_readdata == 32'h0403_0201) else $error("channel roles wrong");

    // Pointers
    chk_file_ptr: assert property (@(posedge clk) disable iff (reset) // [R8]
        (wr_en && avs_address == `REG_FILE_DATA) |=> faddr_r == $past(faddr_r) + 1'b1)
        else $error("file pointer stuck");
    chk_obj_next: assert property (@(posedge clk) disable iff (reset) // [R9]
        (rd_en && avs_address == `REG_OBJ_DATA) |=> oidx_r == $past(oidx_r) + 1'b1)
        else $error("object index stuck");

    // Interrupt status is sticky until its own read, so no event is lost
    chk_irq_sticky: assert property (@(posedge clk) disable iff (reset) // [R2]
        !(rd_en && avs_address == `REG_IRQ_STATUS) |=>
        ((irq_stat_r & $past(irq_stat_r)) == $past(irq_stat_r)))
        else $error("interrupt status lost");
endmodule // slave_state
`default_nettype wire

// ===== rtl/slave_state_defs.svh
// Register offsets, field positions, codes and sizes of the slave state block
// ==========================================
// Operation
// R1 - The block has five operating states and tries to enter whichever one the master asks for.
// R2 - A failed state change sets the error indication and leaves the block in its previous state.
// R3 - The master may ask to clear the error indication; the state then reads back without it.
// R4 - The current state is always readable and is kept apart from the last requested state.
// R5 - Each port reports carrier present and open or closed, in any of the four combinations.
// R6 - With a mailbox, channel 0 carries master-written and channel 1 master-read mailbox data.
// R7 - Channel 2 carries process data out from the master and channel 3 process data back.
// R8 - The block accepts a file written by the master and returns the stored file when read.
// R9 - The block delivers its object list on request through the information service.
// R10 - State moves only on a request, and the error shows with the state in one status word.
`ifndef SLAVE_STATE_DEFS_SVH
`define SLAVE_STATE_DEFS_SVH

// ==========================================
// Register word addresses (byte address / 4)
`define REG_CONTROL 4'h0
`define REG_STATUS 4'h1
`define REG_REQUESTED 4'h2
`define REG_PORTS 4'h3
`define REG_CHANNELS 4'h4
`define REG_FILE_ADDR 4'h5
`define REG_FILE_DATA 4'h6
`define REG_OBJ_INDEX 4'h7
`define REG_OBJ_DATA 4'h8
`define REG_IRQ_STATUS 4'h9
`define REG_IRQ_MASK 4'hA

// ==========================================
// Status and control field positions
`define CTRL_REQ_VALID 8
`define CTRL_CLEAR_ERR 9
`define CTRL_FAIL 10
`define STAT_ERR_BIT 4
`define STATE_W 4

// ==========================================
// State codes
`define ST_INIT 4'h1
`define ST_PRE_OPER 4'h2
`define ST_BOOT 4'h3
`define ST_SAFE_OPER 4'h4
`define ST_OPER 4'h8

// ==========================================
// Channel roles and sizes
`define CH_MBX_WRITE 8'h01
`define CH_MBX_READ 8'h02
`define CH_PD_OUT 8'h03
`define CH_PD_IN 8'h04
`define FILE_DEPTH 16
`define FILE_AW 4
`define OBJ_COUNT 4
`define OBJ_AW 2
`define IRQ_W 4
`define IRQ_STATE 0
`define IRQ_ERROR 1
`define IRQ_PORT 2
`define IRQ_FILE 3

`endif

// ===== rtl/slave_state_pkg.sv
// Types shared by the slave state block
package slave_state_pkg;
    typedef struct packed {
        logic [3:0] carrier;
        logic [3:0] open;
    } port_status_t;
    typedef enum logic [1:0] {
        chg_idle,
        chg_wait
    } chg_state_t;
endpackage
